//--- src/branch_eval_pkg.sv
// Package: constants, types and register map of the branch evaluator
package branch_eval_pkg;

    // APB register byte offsets
    localparam logic [7:0] INSTR_OFS = 8'h00;
    localparam logic [7:0] FLAGS_OFS = 8'h04;
    localparam logic [7:0] PC_OFS = 8'h08;
    localparam logic [7:0] STATE_OFS = 8'h0C;

    // Widths of the instruction fields
    localparam int OP_W = 4;
    localparam int OFFSET_W = 7;
    localparam int FLAG_SEL_W = 3;
    localparam int INSTR_W = OP_W + OFFSET_W + FLAG_SEL_W;

    // Bit positions inside the status flags register
    localparam logic [2:0] FLAG_C_POS = 3'h0;
    localparam logic [2:0] FLAG_Z_POS = 3'h1;
    localparam logic [2:0] FLAG_N_POS = 3'h2;
    localparam logic [2:0] FLAG_V_POS = 3'h3;

    // Bit positions inside the state register
    localparam int ST_BUSY_POS = 0;
    localparam int ST_TAKEN_POS = 1;
    localparam int ST_BAD_OP_POS = 2;
    localparam int ST_DONE_POS = 3;
    localparam int ST_STATE_LSB = 4;

    // Values after reset
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    // Cycle counts of one branch
    localparam int NOT_TAKEN_CYCLES = 1;
    localparam int TAKEN_CYCLES = 2;

    // Branch opcodes
    typedef enum logic [OP_W-1:0] {
        branch_on_flag_clear = 4'h0,
        branch_if_equal = 4'h1,
        branch_if_not_equal = 4'h2,
        branch_if_carry_set = 4'h3,
        branch_if_carry_clear = 4'h4,
        branch_same_or_higher = 4'h5,
        branch_if_lower = 4'h6,
        branch_if_minus = 4'h7,
        branch_if_plus = 4'h8,
        branch_signed_ge = 4'h9
    } br_op_e;

    // Instruction word as written to the instruction register
    typedef struct packed {
        logic [OP_W-1:0] op;
        logic [OFFSET_W-1:0] offset;
        logic [FLAG_SEL_W-1:0] flag_sel;
    } instr_s;

    // Sequencer states, Gray coded along idle, eval, jump
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EVAL = 2'h1,
        ST_JUMP = 2'h3
    } fsm_e;

endpackage : branch_eval_pkg

//--- src/branch_condition.sv
// Condition test of one conditional relative branch
`timescale 1ns/100ps
module branch_condition
    import branch_eval_pkg::*;
(
    // Decoded instruction
    input wire logic [OP_W-1:0] op,
    input wire logic [FLAG_SEL_W-1:0] flag_sel,
    // Current status flags
    input wire logic [7:0] flags,
    // Result
    output logic take,
    output logic bad_op
);

    logic c_flag;
    logic z_flag;
    logic n_flag;
    logic v_flag;

    // Named flags from their fixed positions
    assign c_flag = flags[FLAG_C_POS];
    assign z_flag = flags[FLAG_Z_POS];
    assign n_flag = flags[FLAG_N_POS];
    assign v_flag = flags[FLAG_V_POS];

    // One condition per opcode; unknown opcodes fall through untaken
    always_comb begin
        take = 1'b0;
        bad_op = 1'b0;
        case (op)
            branch_on_flag_clear: take = (flags[flag_sel] == 1'b0);
            branch_if_equal: take = (z_flag == 1'b1);
            branch_if_not_equal: take = (z_flag == 1'b0);
            branch_if_carry_set: take = (c_flag == 1'b1);
            branch_if_carry_clear: take = (c_flag == 1'b0);
            branch_same_or_higher: take = (c_flag == 1'b0);
            branch_if_lower: take = (c_flag == 1'b1);
            branch_if_minus: take = (n_flag == 1'b1);
            branch_if_plus: take = (n_flag == 1'b0);
            branch_signed_ge: take = ((n_flag ^ v_flag) == 1'b0);
            default: bad_op = 1'b1;
        endcase
    end

endmodule : branch_condition

//--- src/conditional_branch_evaluator.sv
// Conditional relative branch evaluator with an APB register port
`timescale 1ns/100ps

// Overview of operation
// - flag-clear branch tests selected flag for 0
// - equal branch taken when zero is 1
// - not-equal branch taken when zero is 0
// - carry-set branch taken when carry is 1
// - carry-clear branch taken when carry is 0
// - same-or-higher taken when carry is 0
// - lower branch taken when carry is 1
// - minus branch taken when negative is 1
// - plus branch taken when negative is 0
// - signed ge taken when N xor V is 0
// - taken branch loads pc plus offset plus one
// - branches never change any status flag
module conditional_branch_evaluator
    import branch_eval_pkg::*;
#(
    parameter int PC_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Program counter and status towards the core
    output logic [PC_W-1:0] pc,
    output logic pc_load,
    output logic [7:0] status_flags,
    output logic branch_busy,
    output logic branch_done,
    output logic branch_taken
);

    fsm_e state_r;
    fsm_e state_nxt;
    instr_s instr_r;
    logic [7:0] flags_r;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] target_r;
    logic [PC_W-1:0] target_nxt;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic pc_load_r;
    logic done_r;
    logic taken_r;
    logic bad_op_r;
    logic cond_take;
    logic cond_bad;
    logic apb_access;
    logic apb_commit;
    logic wr_commit;
    logic addr_ok;
    logic wr_refused;
    logic issue;
    logic busy_r;
    logic hit_instr;
    logic hit_flags;
    logic hit_pc;
    logic hit_state;
    logic wr_ok;
    logic wr_instr;
    logic wr_flags;
    logic wr_pc;
    logic [31:0] rd_word;
    logic [PC_W-1:0] offset_ext;
    logic in_eval;
    logic branch_end;

    // Condition test on the stored instruction and current flags
    branch_condition i_branch_condition (
        .op(instr_r.op),
        .flag_sel(instr_r.flag_sel),
        .flags(flags_r),
        .take(cond_take),
        .bad_op(cond_bad)
    );

    // APB phases; pready comes one cycle into the access phase
    assign apb_access = psel & penable;
    assign apb_commit = apb_access & pready_r;
    assign wr_commit = apb_commit & pwrite;

    // Address decode of the four mapped words
    always_comb begin
        hit_instr = 1'b0;
        hit_flags = 1'b0;
        hit_pc = 1'b0;
        hit_state = 1'b0;
        if (paddr == INSTR_OFS) begin
            hit_instr = 1'b1;
        end else if (paddr == FLAGS_OFS) begin
            hit_flags = 1'b1;
        end else if (paddr == PC_OFS) begin
            hit_pc = 1'b1;
        end else if (paddr == STATE_OFS) begin
            hit_state = 1'b1;
        end
    end
    assign addr_ok = hit_instr | hit_flags | hit_pc | hit_state;

    // Writes while a branch runs would tear pc or flags, so refuse them
    assign wr_refused = pwrite & (!addr_ok | hit_state
                        | (state_r != ST_IDLE));

    // Refusal is fixed in the wait state; a write lands only if not refused
    assign wr_ok = wr_commit & !pslverr_r;
    assign wr_instr = wr_ok & hit_instr;
    assign wr_flags = wr_ok & hit_flags;
    assign wr_pc = wr_ok & hit_pc;
    assign issue = wr_instr;

    // Evaluation cycle, and the cycle in which a branch finishes
    assign in_eval = (state_r == ST_EVAL);
    assign branch_end = (in_eval & !cond_take) | (state_r == ST_JUMP);

    // Offset sign extended so that a taken branch can jump backward
    assign offset_ext = PC_W'($signed(instr_r.offset));
    assign target_nxt = pc_r + offset_ext + PC_W'(1);

    // APB handshake: one wait state, then ready for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= apb_access & !pready_r;
        end
    end

    // Refusal decided in the wait state, shown beside ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= apb_access & !pready_r
                         & (pwrite ? wr_refused : !addr_ok);
        end
    end

    // Read mux, zero for unmapped words
    always_comb begin
        rd_word = 32'h00000000;
        if (hit_instr) begin
            rd_word[INSTR_W-1:0] = instr_r;
        end else if (hit_flags) begin
            rd_word[7:0] = flags_r;
        end else if (hit_pc) begin
            rd_word[PC_W-1:0] = pc_r;
        end else if (hit_state) begin
            rd_word[ST_BUSY_POS] = busy_r;
            rd_word[ST_TAKEN_POS] = taken_r;
            rd_word[ST_BAD_OP_POS] = bad_op_r;
            rd_word[ST_DONE_POS] = done_r;
            rd_word[ST_STATE_LSB+1:ST_STATE_LSB] = state_r;
        end
    end

    // Read data captured in the wait state, so it stands with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (apb_access & !pready_r & !pwrite) begin
            prdata_r <= rd_word;
        end
    end

    // Instruction register; writing it starts a branch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= '0;
        end else if (issue) begin
            instr_r <= pwdata[INSTR_W-1:0];
        end
    end

    // Status flags: only software writes them, the sequencer never does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= FLAGS_RST;
        end else if (wr_flags) begin
            flags_r <= pwdata[7:0];
        end
    end

    // Sequencer: eval decides, jump adds the second cycle of a taken branch
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (issue) begin
                    state_nxt = ST_EVAL;
                end
            end
            ST_EVAL: begin
                if (cond_take) begin
                    state_nxt = ST_JUMP;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_JUMP: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Busy taken from the next state so it tracks the sequencer exactly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    // Target held across the jump cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_r <= '0;
        end else if (in_eval) begin
            target_r <= target_nxt;
        end
    end

    // Program counter: sequential step, jump, or software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= PC_W'(PC_RST);
        end else if (in_eval & !cond_take) begin
            pc_r <= pc_r + PC_W'(1);
        end else if (state_r == ST_JUMP) begin
            pc_r <= target_r;
        end else if (wr_pc) begin
            pc_r <= pwdata[PC_W-1:0];
        end
    end

    // Pc load pulse in the cycle after a branch moved the pc
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_load_r <= 1'b0;
        end else begin
            pc_load_r <= branch_end;
        end
    end

    // Done pulse, one cycle, together with the pc load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= branch_end;
        end
    end

    // Sticky result of the last branch, kept until the next evaluation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_r <= 1'b0;
        end else if (in_eval) begin
            taken_r <= cond_take;
        end
    end

    // Illegal opcode of the last branch; such a branch still steps the pc
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_op_r <= 1'b0;
        end else if (in_eval) begin
            bad_op_r <= cond_bad;
        end
    end

    // APB outputs straight from flip-flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Core outputs straight from flip-flops
    assign pc = pc_r;
    assign pc_load = pc_load_r;
    assign status_flags = flags_r;
    assign branch_busy = busy_r;
    assign branch_done = done_r;
    assign branch_taken = taken_r;

endmodule : conditional_branch_evaluator

//--- test/conditional_branch_evaluator_monitor.sv
// Port checker for the conditional branch evaluator
`timescale 1ns/100ps
module conditional_branch_evaluator_monitor
    import branch_eval_pkg::*;
#(
    parameter int PC_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core side
    input wire logic [PC_W-1:0] pc,
    input wire logic pc_load,
    input wire logic [7:0] status_flags,
    input wire logic branch_busy,
    input wire logic branch_done,
    input wire logic branch_taken
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Busy for the evaluation cycle only, or for evaluation and jump
    sequence s_short;
        $rose(branch_busy) ##1 !branch_busy;
    endsequence
    sequence s_long;
        $rose(branch_busy) ##1 branch_busy;
    endsequence

    property p_not_taken;
        s_short |-> branch_done && !branch_taken && pc == $past(pc) + 1'b1;
    endproperty
    property p_taken;
        s_long |=> branch_done && branch_taken && !branch_busy;
    endproperty
    property p_bounded;
        $rose(branch_busy) |-> ##[1:2] branch_done;
    endproperty
    // Software writes are refused while busy, so flags must hold
    property p_flags_hold;
        branch_busy |=> $stable(status_flags);
    endproperty
    property p_done_pulse;
        branch_done |=> !branch_done;
    endproperty
    property p_load_done;
        pc_load |-> branch_done;
    endproperty
    property p_one_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty

    a_not_taken: assert property (p_not_taken) else $error("untaken bad");
    a_taken: assert property (p_taken) else $error("taken bad");
    a_bounded: assert property (p_bounded) else $error("no done");
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
    a_done_pulse: assert property (p_done_pulse) else $error("done long");
    a_load_done: assert property (p_load_done) else $error("load alone");
    a_one_wait: assert property (p_one_wait) else $error("wait state");
    a_err_ready: assert property (p_err_ready) else $error("err alone");
endmodule : conditional_branch_evaluator_monitor

bind conditional_branch_evaluator conditional_branch_evaluator_monitor #(
    .PC_W(PC_W)
) i_conditional_branch_evaluator_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc(pc), .pc_load(pc_load),
    .status_flags(status_flags), .branch_busy(branch_busy),
    .branch_done(branch_done), .branch_taken(branch_taken)
);

//--- test/conditional_branch_evaluator_test.sv
// Self-checking bench for the conditional branch evaluator
`timescale 1ns/100ps
module conditional_branch_evaluator_test import branch_eval_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tk;
    logic pc_load, branch_busy, branch_done, branch_taken;
    logic [7:0] paddr, status_flags, fl;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] pc, exp_pc;
    logic [6:0] k;
    logic [2:0] s;
    int fails, checks_done, n, i, op, j;
    bit held;
    logic [7:0] fl_tab[4] = '{8'h00, 8'h0F, 8'h05, 8'h0A};

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    conditional_branch_evaluator i_conditional_branch_evaluator (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pc(pc), .pc_load(pc_load),
        .status_flags(status_flags), .branch_busy(branch_busy),
        .branch_done(branch_done), .branch_taken(branch_taken)
    );

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One APB transfer; hold keeps psel up for a setup that follows at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input bit hold = 1'b0);
        int t;
        if (!held) @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (t = 0; t < 20; t++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (t == 20) begin
            fails++;
            stop_test();
        end
        q = prdata;
        err = pslverr;
        penable <= 1'b0;
        if (!hold) psel <= 1'b0;
        held = hold;
    endtask : apb

    // Expected outcome of each branch kind
    function automatic logic exp_take(int o, logic [7:0] f, logic [2:0] x);
        case (o)
            0: return !f[x];
            1: return f[FLAG_Z_POS];
            2: return !f[FLAG_Z_POS];
            3, 6: return f[FLAG_C_POS];
            4, 5: return !f[FLAG_C_POS];
            7: return f[FLAG_N_POS];
            8: return !f[FLAG_N_POS];
            9: return !(f[FLAG_N_POS] ^ f[FLAG_V_POS]);
            default: return 1'b0;
        endcase
    endfunction : exp_take

    // Reset, register checks, then every opcode against four flag sets
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, FLAGS_OFS, 32'h0);
        check("flags_rst", q, 32'(FLAGS_RST));
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped", {q[30:0], err}, 32'h1);
        apb(1'b1, STATE_OFS, 32'hF);
        check("state_wr_err", 32'(err), 32'h1);
        apb(1'b1, PC_OFS, 32'h0100);
        exp_pc = 16'h0100;
        for (op = 0; op < 11; op++) begin
            for (j = 0; j < 4; j++) begin
                fl = fl_tab[j];
                k = j[0] ? 7'h40 : 7'h3F; // Both ends of the offset range
                s = 3'(op + j);
                tk = exp_take(op, fl, s);
                apb(1'b1, FLAGS_OFS, 32'(fl));
                apb(1'b1, INSTR_OFS, 32'({4'(op), k, s}));
                n = 0;
                for (i = 0; i < 8; i++) begin
                    #1;
                    if (branch_done === 1'b1) break;
                    n++;
                    @(posedge pclk);
                end
                if (i == 8) begin
                    fails++;
                    stop_test();
                end
                exp_pc = exp_pc + (tk ? {{9{k[6]}}, k} + 16'h1 : 16'h1);
                check("pc", 32'(pc), 32'(exp_pc));
                check("pc_load", 32'(pc_load), 32'h1);
                check("taken", 32'(branch_taken), 32'(tk));
                check("cycles", n, tk ? 2 : 1);
                check("flags", 32'(status_flags), 32'(fl));
                @(posedge pclk);
                apb(1'b0, STATE_OFS, 32'h0);
                check("state", q, 32'({op > 9, tk, 1'b0}));
            end
        end
        // Flag write right behind a taken branch is refused in its jump cycle
        apb(1'b1, FLAGS_OFS, 32'h02);
        apb(1'b1, INSTR_OFS, 32'({4'h1, 7'h02, 3'h0}), 1'b1);
        apb(1'b1, FLAGS_OFS, 32'h0F);
        check("busy_wr_err", 32'(err), 32'h1);
        apb(1'b0, FLAGS_OFS, 32'h0);
        check("busy_flags", q, 32'h02);
        apb(1'b0, PC_OFS, 32'h0);
        check("busy_pc", q, 32'(exp_pc + 16'h3));
        stop_test();
    end
endmodule : conditional_branch_evaluator_test
